/* File: rtl/gev_event_logic.sv */
`timescale 1ns/1ps
module gev_event_logic
  import gev_pkg::*;
(
  // clock and reset
  input  wire logic                           mclk,
  input  wire logic                           resetn,
  // configuration access
  input  wire gev_cfg_req_type                cfg_req,
  output logic [15:0]                         cfg_rdata,
  output logic                                cfg_ack,
  // socket state from card control logic
  input  wire logic [1:0]                     video_port_enable,
  input  wire gev_sock_pwr_type [1:0]         sock_pwr,
  // multifunction terminal inputs: bit order pins 0,1,2,4,5
  input  wire logic [GEV_NUM_INPUTS-1:0]      multi_pin_in,
  input  wire logic [GEV_NUM_INPUTS-1:0]      pin_is_input,
  input  wire logic                           event_pin_routed,
  // event output to host chipset
  output logic                                general_event_out_n
);

  typedef struct packed {
    logic [15:0]                flags;
    logic [15:0]                enables;
    logic [GEV_NUM_INPUTS-1:0]  sync1;
    logic [GEV_NUM_INPUTS-1:0]  sync2;
    logic [GEV_NUM_INPUTS-1:0]  sync3;
    logic [GEV_NUM_INPUTS-1:0]  level;
    logic                       primed;
    logic [1:0]                 video_prev;
    gev_sock_pwr_type [1:0]     pwr_prev;
    logic [15:0]                rdata;
    logic                       ack;
    logic                       event_n;
  } gev_state_type;

  gev_state_type st_q;
  gev_state_type st_d;

  function automatic logic [15:0] lane_mask(input logic [1:0] be);
    lane_mask = {{8{be[1]}}, {8{be[0]}}};
  endfunction : lane_mask

  function automatic logic hit(input gev_cfg_req_type r, input logic [7:0] ofs);
    hit = r.valid && (r.func == GEV_FUNC0) && (r.offset == ofs);
  endfunction : hit

  logic [15:0]               set_vec;
  logic [15:0]               clr_vec;
  logic [15:0]               gate_vec;
  logic [GEV_NUM_INPUTS-1:0] settled;
  logic [GEV_NUM_INPUTS-1:0] changed;
  logic [1:0]                hi12_now;
  logic [1:0]                hi12_prev;

  always_comb begin
    st_d = st_q;
    // three stage sync; second and third must agree before a level counts
    st_d.sync1 = multi_pin_in;
    st_d.sync2 = st_q.sync1;
    st_d.sync3 = st_q.sync2;
    settled    = ~(st_q.sync2 ^ st_q.sync3);
    changed    = '0;
    for (int i = 0; i < GEV_NUM_INPUTS; i++) begin
      if (settled[i]) begin
        st_d.level[i] = st_q.sync3[i];
        changed[i]    = st_q.primed && (st_q.sync3[i] != st_q.level[i]);
      end
    end
    // first settled sample after reset is a baseline, not an event
    st_d.primed = st_q.primed | (&settled);

    for (int s = 0; s < 2; s++) begin
      hi12_now[s]  = (sock_pwr[s].vpp == GEV_VPP_12V);
      hi12_prev[s] = (st_q.pwr_prev[s].vpp == GEV_VPP_12V);
    end
    st_d.video_prev = video_port_enable;
    st_d.pwr_prev   = sock_pwr;

    set_vec                 = '0;
    set_vec[GEV_BIT_VIDEO0] = video_port_enable[0] ^ st_q.video_prev[0];
    set_vec[GEV_BIT_VIDEO1] = video_port_enable[1] ^ st_q.video_prev[1];
    set_vec[GEV_BIT_POWER]  = (sock_pwr != st_q.pwr_prev);
    set_vec[GEV_BIT_PROG12] = |(hi12_now ^ hi12_prev);
    set_vec[GEV_BIT_INPUT0 +: GEV_NUM_INPUTS] = changed;

    // write one to clear, zero leaves alone; a same-cycle event wins
    clr_vec = '0;
    if (hit(cfg_req, GEV_FLAGS_OFS) && cfg_req.write) begin
      clr_vec = cfg_req.wdata & lane_mask(cfg_req.be);
    end
    // flags ignore the enables entirely
    st_d.flags = ((st_q.flags & ~clr_vec) | set_vec) & GEV_IMPL_MASK;

    if (hit(cfg_req, GEV_ENABLES_OFS) && cfg_req.write) begin
      st_d.enables = ((st_q.enables & ~lane_mask(cfg_req.be))
                     | (cfg_req.wdata & lane_mask(cfg_req.be))) & GEV_IMPL_MASK;
    end

    // reads of function 1 or other offsets return zero
    st_d.ack   = cfg_req.valid;
    st_d.rdata = '0;
    if (hit(cfg_req, GEV_FLAGS_OFS) && !cfg_req.write) begin
      st_d.rdata = st_q.flags & GEV_IMPL_MASK;
    end else if (hit(cfg_req, GEV_ENABLES_OFS) && !cfg_req.write) begin
      st_d.rdata = st_q.enables & GEV_IMPL_MASK;
    end

    // terminal inputs only signal while configured as inputs
    gate_vec = GEV_IMPL_MASK;
    gate_vec[GEV_BIT_INPUT0 +: GEV_NUM_INPUTS] = pin_is_input;
    // level output: stays low until software clears the flag or its enable, its terminal stops being an input, or event_pin_routed drops
    st_d.event_n = ~(event_pin_routed
                     && |(st_q.flags & st_q.enables & gate_vec));
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_q            <= '0;
      st_q.flags      <= GEV_FLAGS_RESET;
      st_q.enables    <= GEV_ENABLES_RESET;
      st_q.event_n    <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign cfg_rdata           = st_q.rdata;
  assign cfg_ack             = st_q.ack;
  assign general_event_out_n = st_q.event_n;

endmodule : gev_event_logic

/* File: rtl/gev_pkg.sv */
package gev_pkg;

  // configuration space offsets, reached through function 0 only
  localparam logic [7:0]  GEV_FLAGS_OFS     = 8'ha8;
  localparam logic [7:0]  GEV_ENABLES_OFS   = 8'haa;
  localparam logic [2:0]  GEV_FUNC0         = 3'h0;

  // flag / enable bit positions
  localparam int          GEV_BIT_VIDEO0    = 15;
  localparam int          GEV_BIT_VIDEO1    = 14;
  localparam int          GEV_BIT_POWER     = 11;
  localparam int          GEV_BIT_PROG12    = 8;
  localparam int          GEV_BIT_INPUT0    = 0;
  localparam int          GEV_NUM_INPUTS    = 5;

  // implemented bits; everything else reads zero and ignores writes
  localparam logic [15:0] GEV_IMPL_MASK     = 16'hc91f;
  localparam logic [15:0] GEV_FLAGS_RESET   = 16'h0000;
  localparam logic [15:0] GEV_ENABLES_RESET = 16'h0000;

  // programming-voltage request code meaning 12 V
  localparam logic [1:0]  GEV_VPP_12V       = 2'h2;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [2:0] func;
    logic [7:0] offset;
    logic [1:0] be;
    logic [15:0] wdata;
  } gev_cfg_req_type;

  typedef struct packed {
    logic [1:0] vcc;
    logic [1:0] vpp;
  } gev_sock_pwr_type;

endpackage : gev_pkg

/* File: verification/gev_checker.sv */
`timescale 1ns/1ps
module gev_checker
  import gev_pkg::*;
(
  // clock, reset, config port
  input wire logic                   mclk,
  input wire logic                   resetn,
  input wire gev_cfg_req_type        cfg_req,
  input wire logic [15:0]            cfg_rdata,
  input wire logic                   cfg_ack,
  // event sources and output
  input wire logic [1:0]             video_port_enable,
  input wire gev_sock_pwr_type [1:0] sock_pwr,
  input wire logic [4:0]             multi_pin_in,
  input wire logic [4:0]             pin_is_input,
  input wire logic                   event_pin_routed,
  input wire logic                   general_event_out_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  AST_ACK: assert property (cfg_req.valid |=> cfg_ack) else $error("no ack");
  AST_IDLE: assert property (!cfg_req.valid |=> !cfg_ack && cfg_rdata == 16'h0) else $error("stray ack");
  AST_FUNC: assert property (cfg_req.valid && cfg_req.func != GEV_FUNC0 |=> cfg_rdata == 16'h0)
    else $error("other function answered");
  AST_OFS: assert property (cfg_req.valid && cfg_req.offset != GEV_FLAGS_OFS && cfg_req.offset != GEV_ENABLES_OFS
    |=> cfg_rdata == 16'h0) else $error("unmapped read");
  AST_RSVD: assert property (cfg_ack |-> (cfg_rdata & ~16'hc91f) == 16'h0) else $error("reserved bit");
  AST_ROUTE: assert property (!event_pin_routed |=> general_event_out_n) else $error("unrouted event");
  AST_HOLD: assert property (!general_event_out_n && event_pin_routed && $stable(pin_is_input)
    && !cfg_req.valid && !$past(cfg_req.valid) |=> !general_event_out_n) else $error("event dropped");
  AST_ENOFF: assert property (cfg_req.valid && cfg_req.write && cfg_req.func == GEV_FUNC0 && cfg_req.be == 2'h3
    && cfg_req.offset == GEV_ENABLES_OFS && cfg_req.wdata == 16'h0 |=> ##1 general_event_out_n) else $error("masked");
endmodule : gev_checker
bind gev_event_logic gev_checker i_chk (.mclk, .resetn, .cfg_req, .cfg_rdata, .cfg_ack, .video_port_enable,
  .sock_pwr, .multi_pin_in, .pin_is_input, .event_pin_routed, .general_event_out_n);

/* File: verification/gev_host_model.sv */
`timescale 1ns/1ps
module gev_host_model (
  // event line in, latched level out
  input wire logic mclk,
  input wire logic resetn,
  input wire logic general_event_out_n,
  output logic     event_seen
);
  // one flop of latency, as a chipset input stage would add
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      event_seen <= 1'b0;
    end else begin
      event_seen <= !general_event_out_n;
    end
  end
endmodule : gev_host_model

/* File: verification/test_general_event_logic.sv */
`timescale 1ns/1ps
module test_general_event_logic;
  import gev_pkg::*;
  logic mclk = 0, resetn = 0, event_pin_routed = 1, cfg_ack, general_event_out_n, seen;
  gev_cfg_req_type cfg_req = '0;
  logic [15:0] cfg_rdata, tab[9] = '{16'h8000, 16'h4000, 16'h800, 16'h900, 16'h1, 16'h2, 16'h4, 16'h8, 16'h10};
  logic [1:0] video_port_enable = 0;
  gev_sock_pwr_type [1:0] sock_pwr = '0;
  logic [4:0] multi_pin_in = 0, pin_is_input = 5'h1f;
  logic [16:0] exp_q[$];
  int err_count = 0, num_checks = 0, seed = 32'h87ab27a6, i;
  always #2.5 mclk = ~mclk;
  gev_event_logic i_dut (.mclk, .resetn, .cfg_req, .cfg_rdata, .cfg_ack, .video_port_enable, .sock_pwr,
    .multi_pin_in, .pin_is_input, .event_pin_routed, .general_event_out_n);
  gev_host_model i_host (.mclk, .resetn, .general_event_out_n, .event_seen(seen));
  task automatic chk(logic [15:0] got, logic [15:0] want);
    num_checks++;
    if (got !== want) begin
      err_count++;
      $display("Error %0t: %h vs %h", $time, got, want);
    end
  endtask : chk
  task automatic acc(logic w, logic [7:0] o, logic [15:0] d, logic [16:0] x, logic [2:0] f = GEV_FUNC0);
    cfg_req = '{1'b1, w, f, o, 2'h3, d};
    exp_q.push_back(x);
    @(posedge mclk) #1;
  endtask : acc
  task automatic idl(int n);
    cfg_req.valid = 0;
    repeat (n) @(posedge mclk);
    #1;
  endtask : idl
  task automatic final_report;
    if (exp_q.size() != 0) err_count++;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  // oldest note answers each ack; sampled mid-cycle, away from the launching edge
  always @(negedge mclk) if (cfg_ack === 1'b1) begin
    if (exp_q.size() == 0) begin
      chk(16'h1, 16'h0);
    end else begin
      if (exp_q[0][16]) chk(cfg_rdata, exp_q[0][15:0]);
      void'(exp_q.pop_front());
    end
  end
  initial begin
    repeat (100000) @(posedge mclk);
    err_count++;
    final_report();
  end
  initial begin
    repeat (20) @(posedge mclk);
    #1 resetn = 1;
    acc(0, GEV_FLAGS_OFS, 0, 17'h10000);
    acc(1, GEV_ENABLES_OFS, 16'hffff, 0);
    acc(0, GEV_ENABLES_OFS, 0, 17'h1c91f);
    for (i = 0; i < 9; i++) begin
      case (i)
        0, 1: video_port_enable[i] = 1;
        2: sock_pwr[0].vcc = 2'h1;
        3: sock_pwr[1].vpp = GEV_VPP_12V;
        default: multi_pin_in[i-4] = 1;
      endcase
      idl(8);
      chk({15'h0, seen}, 1);
      acc(1, GEV_FLAGS_OFS, 16'($random(seed)) & ~tab[i], 0);
      acc(0, GEV_FLAGS_OFS, 0, {1'b1, tab[i]});
      acc(1, GEV_FLAGS_OFS, 16'($random(seed)) | tab[i], 0);
      idl(3);
      acc(0, GEV_FLAGS_OFS, 0, 17'h10000);
      idl(3);
      chk({15'h0, seen}, 0);
      $display("event %0d done", i);
    end
    acc(1, GEV_ENABLES_OFS, 0, 0, 3'h1);
    acc(0, GEV_ENABLES_OFS, 0, 17'h1c91f);
    acc(0, 8'hac, 0, 17'h10000);
    pin_is_input = 0;
    multi_pin_in[0] = 0;
    idl(8);
    chk({15'h0, seen}, 0);
    acc(1, GEV_FLAGS_OFS, 16'hffff, 0);
    event_pin_routed = 0;
    video_port_enable[0] = 0;
    idl(8);
    chk({15'h0, seen}, 0);
    acc(1, GEV_ENABLES_OFS, 0, 0);
    event_pin_routed = 1;
    video_port_enable[1] = 0;
    idl(8);
    chk({15'h0, seen}, 0);
    acc(0, GEV_FLAGS_OFS, 0, 17'h1c000);
    idl(3);
    final_report();
  end
endmodule : test_general_event_logic
